/* File: src/rtc_pkg.sv */
// constants, command codes, property map and carriers of the tuner engine
package rtc_pkg;

  localparam int          PROP_COUNT = 27;
  localparam logic [15:0] PROP_ADDR [PROP_COUNT] = '{
    16'h0001, 16'h0102, 16'h0104, 16'h0201, 16'h0202, 16'h1100, 16'h1105,
    16'h1106, 16'h1108, 16'h1200, 16'h1201, 16'h1202, 16'h1203, 16'h1204,
    16'h1207, 16'h1302, 16'h1303, 16'h1400, 16'h1401, 16'h1402, 16'h1403,
    16'h1404, 16'h1500, 16'h1501, 16'h1502, 16'h4000, 16'h4001};
  localparam logic [15:0] PROP_DEFAULT [PROP_COUNT] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0001, 16'h0002, 16'h0031,
    16'h001e, 16'h001e, 16'h0000, 16'h007f, 16'h0000, 16'h007f, 16'h0000,
    16'h0081, 16'h0010, 16'h0004, 16'h222e, 16'h2a26, 16'h000a, 16'h0003,
    16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h003f, 16'h0000};

  // positions in the property store
  localparam logic [4:0] IDX_INT_ENABLE   = 5'h00;
  localparam logic [4:0] IDX_SAMPLE_RATE  = 5'h02;
  localparam logic [4:0] IDX_REFERENCE_CLOCK_FREQUENCY  = 5'h03;
  localparam logic [4:0] IDX_STEREO_BLEND = 5'h06;
  localparam logic [4:0] IDX_MONO_BLEND   = 5'h07;
  localparam logic [4:0] IDX_MAX_TUNE_ERR = 5'h08;
  localparam logic [4:0] IDX_QUALITY_SRC  = 5'h09;
  localparam logic [4:0] IDX_STRENGTH_HI  = 5'h0c;
  localparam logic [4:0] IDX_STRENGTH_LO  = 5'h0d;
  localparam logic [4:0] IDX_SOFT_MUTE    = 5'h0f;
  localparam logic [4:0] IDX_BAND_BOTTOM  = 5'h11;
  localparam logic [4:0] IDX_BAND_TOP     = 5'h12;
  localparam logic [4:0] IDX_SPACING      = 5'h13;
  localparam logic [4:0] IDX_FIFO_THRESH  = 5'h17;
  localparam logic [4:0] IDX_HARD_MUTE    = 5'h1a;

  localparam logic [15:0] REFCLK_MIN    = 16'h799a;
  localparam logic [15:0] REFCLK_MAX    = 16'h8666;
  localparam logic [7:0]  BLEND_FORCE_M = 8'h7f;

  typedef enum logic [7:0] {
    CMD_POWER_UP     = 8'h01,
    CMD_REVISION     = 8'h10,
    CMD_POWER_DOWN   = 8'h11,
    CMD_SET_PROPERTY = 8'h12,
    CMD_PROPERTY_READ_CMD = 8'h13,
    CMD_IRQ_FLAGS    = 8'h14,
    CMD_FIRMWARE_PATCH_ARGUMENT_CMD   = 8'h15,
    CMD_FIRMWARE_PATCH_PAYLOAD_CMD   = 8'h16,
    CMD_TUNE         = 8'h20,
    CMD_SCAN         = 8'h21,
    CMD_TUNE_RESULT  = 8'h22,
    CMD_QUALITY      = 8'h23,
    CMD_BCAST_DATA   = 8'h24,
    CMD_AUX_DRIVE    = 8'h80,
    CMD_AUX_LEVEL    = 8'h81
  } rtc_cmd_code_type;

  // status byte bit positions
  localparam int ST_CTS  = 7;
  localparam int ST_ERR  = 6;
  localparam int ST_QUAL = 3;
  localparam int ST_DATA = 2;
  localparam int ST_TUNE = 0;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int SCAN_DWELL_NS   = 5000;
  localparam int SCAN_DWELL_CYC  =
    (SCAN_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN  = 2'b10
  } rtc_scan_state_type;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  arg;
    logic [15:0] addr;
    logic [15:0] value;
  } rtc_cmd_type;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  info;
    logic [15:0] data;
  } rtc_resp_type;

endpackage

/* File: src/rtc_engine.sv */
// command decoder, property store, scan engine and data queue of the tuner
// Contract
// RULE1 - 0x01 powers up with mode, 0x10 returns revision, 0x11 powers down.
// RULE2 - 0x12 writes the addressed property, 0x13 returns its current value.
// RULE3 - 0x14 returns the current interrupt status flags.
// RULE4 - 0x15 and 0x16 are reserved patch download codes, no other effect.
// RULE5 - 0x20 tunes, 0x21 starts a scan, 0x22 reports the last outcome.
// RULE6 - 0x23 reports signal quality; 0x24 returns and pops one queued group.
// RULE7 - 0x80 sets aux pin driven or floating; 0x81 sets its level.
// RULE8 - reference clock takes 31130 to 34406 or zero; zero stops correction.
// RULE9 - above stereo threshold full stereo; 0 forces stereo, 127 mono.
// RULE10 - below mono threshold full mono; 0 forces stereo, 127 mono.
// RULE11 - rail flag rises when frequency error exceeds the maximum tune error.
// RULE12 - soft mute attenuation limited by property; zero disables soft mute.
// RULE13 - group received flag only once queue count reaches programmed count.
// RULE14 - scan stays between band bottom and band top.
// RULE15 - sample rate in 100 Hz units; zero leaves digital audio disabled.
// RULE16 - hard mute mutes audio; left and right muted independently.
// RULE17 - scan steps by the programmed channel spacing.
// RULE18 - interrupt sources enabled one by one; all disabled after reset.
// RULE19 - every command answers a status byte with flags and clear to send.
// RULE20 - reset restores every property default and holds off commands; here reset sets clear to send high.
// RULE21 - properties are 16 bits and read back the last written value.
// RULE22 - host waits for clear to send and avoids patch codes otherwise.
`timescale 1ns/100ps

module rtc_engine #(
  parameter int          QUEUE_DEPTH = 8,
  parameter logic [15:0] REVISION    = 16'h5a01  // arbitrary value
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          cmd_valid,
  input  rtc_pkg::rtc_cmd_type cmd,
  output rtc_pkg::rtc_resp_type resp,
  output logic               resp_valid,
  output logic               cts,
  input  wire logic [15:0]   freq_err,
  input  wire logic [7:0]    rssi,
  input  wire logic          channel_valid,
  input  wire logic          group_valid,
  input  wire logic [15:0]   group_data,
  output logic               int_request,
  output logic               powered,
  output logic [7:0]         power_mode,
  output logic [15:0]        tuned_freq,
  output logic               auto_freq_correction,
  output logic               freq_correction_rail_flag,
  output logic               stereo_full,
  output logic               mono_full,
  output logic               soft_mute_enable,
  output logic [7:0]         soft_mute_atten,
  output logic               digital_audio_enable,
  output logic               mute_left,
  output logic               mute_right,
  output logic               group_received_flag,
  output logic               aux_output_three,
  output logic               aux_output_three_oe
);
  import rtc_pkg::*;

  localparam int PW = $clog2(QUEUE_DEPTH);

  if (QUEUE_DEPTH < 2 || (1 << PW) != QUEUE_DEPTH) begin : g_chk
    $error("QUEUE_DEPTH must be a power of two, at least 2");
  end

  rtc_cmd_type        cmd_q_reg;
  logic               exec_reg;
  logic [15:0]        prop_mem [PROP_COUNT];
  logic [4:0]         prop_idx;
  logic               prop_hit;
  logic               cmd_err;
  logic               exec_ok;
  logic               stc_reg;
  logic               qual_reg;
  logic               valid_reg;
  logic               limit_reg;
  logic               scan_done_reg;
  logic               scan_up_reg;
  rtc_scan_state_type scan_reg;
  logic [15:0]        dwell_reg;
  logic [16:0]        step_next;
  logic [15:0]        queue_mem [QUEUE_DEPTH];
  logic [PW-1:0]      wr_ptr_reg;
  logic [PW-1:0]      rd_ptr_reg;
  logic [PW:0]        count_reg;
  logic               push;
  logic               pop;
  logic [7:0]         flag_vec;
  logic [7:0]         st_thr;
  logic [7:0]         mo_thr;
  logic               force_st;
  logic               force_mo;
  logic               qual_event;
  logic [15:0]        rate_q;
  logic [7:0]         resp_info;
  logic [15:0]        resp_data;

  // command take and one-cycle execute stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q_reg  <= '0;
      exec_reg   <= 1'b0;
      cts        <= 1'b1;                                  // RULE20
      resp_valid <= 1'b0;
      resp       <= '0;
    end else begin
      resp_valid <= 1'b0;
      if (cmd_valid && cts) begin                          // RULE22
        cmd_q_reg <= cmd;
        exec_reg  <= 1'b1;
        cts       <= 1'b0;
      end else if (exec_reg) begin
        exec_reg   <= 1'b0;
        cts        <= 1'b1;
        resp_valid <= 1'b1;                                // RULE19
        resp       <= '{status: flag_vec | ({7'h00, cmd_err} << ST_ERR)
                                 | (8'h01 << ST_CTS),
                        info: resp_info, data: resp_data};
      end
    end
  end

  always_comb begin
    prop_hit = 1'b0;
    prop_idx = 5'h00;
    for (int i = 0; i < PROP_COUNT; i++) begin
      if (PROP_ADDR[i] == cmd_q_reg.addr) begin
        prop_hit = 1'b1;
        prop_idx = i[4:0];
      end
    end
  end

  // errors: unknown code, unmapped property, bad reference clock, powered down
  always_comb begin
    cmd_err = 1'b0;
    case (cmd_q_reg.code)
      CMD_POWER_UP, CMD_FIRMWARE_PATCH_ARGUMENT_CMD, CMD_FIRMWARE_PATCH_PAYLOAD_CMD: cmd_err = 1'b0; // RULE4
      CMD_SET_PROPERTY: begin
        cmd_err = !powered || !prop_hit;
        if (prop_idx == IDX_REFERENCE_CLOCK_FREQUENCY && cmd_q_reg.value != 16'h0000 &&
            (cmd_q_reg.value < REFCLK_MIN || cmd_q_reg.value > REFCLK_MAX))
          cmd_err = 1'b1;                                  // RULE8
      end
      CMD_PROPERTY_READ_CMD: cmd_err = !powered || !prop_hit;
      CMD_REVISION, CMD_POWER_DOWN, CMD_IRQ_FLAGS, CMD_TUNE, CMD_SCAN,
      CMD_TUNE_RESULT, CMD_QUALITY, CMD_BCAST_DATA, CMD_AUX_DRIVE,
      CMD_AUX_LEVEL: cmd_err = !powered;
      default: cmd_err = 1'b1;
    endcase
  end

  assign exec_ok = exec_reg && !cmd_err;

  always_comb begin
    resp_info = 8'h00;
    resp_data = 16'h0000;
    case (cmd_q_reg.code)
      CMD_REVISION:     resp_data = REVISION;              // RULE1
      CMD_PROPERTY_READ_CMD: resp_data = prop_mem[prop_idx];    // RULE2
      CMD_IRQ_FLAGS:    resp_data = {8'h00, flag_vec};     // RULE3
      CMD_TUNE_RESULT: begin                               // RULE5
        resp_data = tuned_freq;
        resp_info = {valid_reg, limit_reg, freq_correction_rail_flag, 5'h00};
      end
      CMD_QUALITY: begin                                   // RULE6
        resp_data = {8'h00, rssi};
        resp_info = {stereo_full, mono_full, freq_correction_rail_flag,
                     channel_valid, 4'h0};
      end
      CMD_BCAST_DATA: begin                                // RULE6
        resp_data = queue_mem[rd_ptr_reg];
        resp_info = 8'(count_reg);
      end
      default: resp_data = 16'h0000;
    endcase
  end

  // property store, defaults on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PROP_COUNT; i++)
        prop_mem[i] <= PROP_DEFAULT[i];                    // RULE20
    end else if (exec_ok && cmd_q_reg.code == CMD_SET_PROPERTY) begin
      prop_mem[prop_idx] <= cmd_q_reg.value;               // RULE21
    end
  end

  // power state and auxiliary pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powered             <= 1'b0;
      power_mode          <= 8'h00;
      aux_output_three    <= 1'b0;
      aux_output_three_oe <= 1'b0;
    end else if (exec_ok) begin
      case (cmd_q_reg.code)
        CMD_POWER_UP: begin                                // RULE1
          powered    <= 1'b1;
          power_mode <= cmd_q_reg.arg;
        end
        CMD_POWER_DOWN: powered <= 1'b0;                   // RULE1
        CMD_AUX_DRIVE: aux_output_three_oe <= cmd_q_reg.arg[0]; // RULE7
        CMD_AUX_LEVEL: aux_output_three    <= cmd_q_reg.arg[0]; // RULE7
        default: powered <= powered;
      endcase
    end
  end

  // tune and scan
  always_comb begin
    if (scan_up_reg)
      step_next = {1'b0, tuned_freq} + {1'b0, prop_mem[IDX_SPACING]};
    else
      step_next = {1'b0, tuned_freq} - {1'b0, prop_mem[IDX_SPACING]};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_reg      <= SCAN_IDLE;
      tuned_freq    <= 16'h0000;
      dwell_reg     <= 16'h0000;
      scan_up_reg   <= 1'b1;
      scan_done_reg <= 1'b0;
      valid_reg     <= 1'b0;
      limit_reg     <= 1'b0;
    end else begin
      scan_done_reg <= 1'b0;
      if (exec_ok && cmd_q_reg.code == CMD_POWER_DOWN) begin
        scan_reg <= SCAN_IDLE;
      end else if (exec_ok && cmd_q_reg.code == CMD_TUNE) begin
        scan_reg      <= SCAN_IDLE;                        // RULE5
        tuned_freq    <= cmd_q_reg.value;
        valid_reg     <= channel_valid;
        limit_reg     <= 1'b0;
        scan_done_reg <= 1'b1;
      end else if (exec_ok && cmd_q_reg.code == CMD_SCAN) begin
        scan_reg    <= SCAN_RUN;                           // RULE5
        scan_up_reg <= cmd_q_reg.arg[3];
        dwell_reg   <= 16'h0000;
        limit_reg   <= 1'b0;
        valid_reg   <= 1'b0;
        if (tuned_freq < prop_mem[IDX_BAND_BOTTOM])
          tuned_freq <= prop_mem[IDX_BAND_BOTTOM];         // RULE14
        else if (tuned_freq > prop_mem[IDX_BAND_TOP])
          tuned_freq <= prop_mem[IDX_BAND_TOP];            // RULE14
      end else begin
        case (scan_reg)
          SCAN_IDLE: scan_reg <= SCAN_IDLE;
          SCAN_RUN: begin
            if (dwell_reg != 16'(SCAN_DWELL_CYC - 1)) begin
              dwell_reg <= dwell_reg + 16'h0001;
            end else begin
              dwell_reg <= 16'h0000;
              if (channel_valid) begin
                scan_reg      <= SCAN_IDLE;
                valid_reg     <= 1'b1;
                scan_done_reg <= 1'b1;
              end else if (step_next > {1'b0, prop_mem[IDX_BAND_TOP]} ||
                           step_next < {1'b0, prop_mem[IDX_BAND_BOTTOM]} ||
                           step_next[16]) begin
                scan_reg      <= SCAN_IDLE;                // RULE14
                limit_reg     <= 1'b1;
                scan_done_reg <= 1'b1;
              end else begin
                tuned_freq <= step_next[15:0];             // RULE17
              end
            end
          end
          default: scan_reg <= SCAN_IDLE;
        endcase
      end
    end
  end

  // received group queue; query pops one entry
  assign push = group_valid && powered && (count_reg != (PW+1)'(QUEUE_DEPTH));
  assign pop  = exec_ok && cmd_q_reg.code == CMD_BCAST_DATA &&
                count_reg != '0;

  always_ff @(posedge clk) begin
    if (push)
      queue_mem[wr_ptr_reg] <= group_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + PW'(1);                 // RULE6
      if (push && !pop)
        count_reg <= count_reg + (PW+1)'(1);
      else if (pop && !push)
        count_reg <= count_reg - (PW+1)'(1);
    end
  end

  // sticky tune and quality flags; a set in the clearing cycle wins
  assign qual_event = (prop_mem[IDX_QUALITY_SRC][0] &&
                       {8'h00, rssi} < prop_mem[IDX_STRENGTH_LO]) ||
                      (prop_mem[IDX_QUALITY_SRC][1] &&
                       {8'h00, rssi} > prop_mem[IDX_STRENGTH_HI]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stc_reg  <= 1'b0;
      qual_reg <= 1'b0;
    end else begin
      if (scan_done_reg)
        stc_reg <= 1'b1;
      else if (exec_ok && cmd_q_reg.code == CMD_TUNE_RESULT &&
               cmd_q_reg.arg[0])
        stc_reg <= 1'b0;
      if (qual_event && powered)
        qual_reg <= 1'b1;
      else if (exec_ok && cmd_q_reg.code == CMD_QUALITY && cmd_q_reg.arg[0])
        qual_reg <= 1'b0;
    end
  end

  always_comb begin
    flag_vec          = 8'h00;
    flag_vec[ST_TUNE] = stc_reg;
    flag_vec[ST_DATA] = group_received_flag;
    flag_vec[ST_QUAL] = qual_reg;
  end

  // settings that steer the signal path
  assign st_thr   = prop_mem[IDX_STEREO_BLEND][7:0];
  assign mo_thr   = prop_mem[IDX_MONO_BLEND][7:0];
  assign force_mo = st_thr == BLEND_FORCE_M || mo_thr == BLEND_FORCE_M;
  assign force_st = st_thr == 8'h00 || mo_thr == 8'h00;
  assign rate_q   = prop_mem[IDX_SAMPLE_RATE];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_request               <= 1'b0;
      auto_freq_correction      <= 1'b0;
      freq_correction_rail_flag <= 1'b0;
      stereo_full               <= 1'b0;
      mono_full                 <= 1'b0;
      soft_mute_enable          <= 1'b0;
      soft_mute_atten           <= 8'h00;
      digital_audio_enable      <= 1'b0;
      mute_left                 <= 1'b0;
      mute_right                <= 1'b0;
      group_received_flag       <= 1'b0;
    end else begin
      int_request <= |(prop_mem[IDX_INT_ENABLE][7:0] & flag_vec); // RULE18
      auto_freq_correction <= prop_mem[IDX_REFERENCE_CLOCK_FREQUENCY] != 16'h0000; // RULE8
      freq_correction_rail_flag <=
        freq_err > prop_mem[IDX_MAX_TUNE_ERR];             // RULE11
      stereo_full <= !force_mo && (force_st || rssi > st_thr); // RULE9
      mono_full   <= force_mo || (!force_st && rssi < mo_thr); // RULE10
      soft_mute_enable <= prop_mem[IDX_SOFT_MUTE] != 16'h0000; // RULE12
      soft_mute_atten  <= prop_mem[IDX_SOFT_MUTE][7:0];    // RULE12
      digital_audio_enable <= rate_q != 16'h0000;          // RULE15
      mute_left  <= prop_mem[IDX_HARD_MUTE][1];            // RULE16
      mute_right <= prop_mem[IDX_HARD_MUTE][0];            // RULE16
      group_received_flag <= count_reg != '0 &&
        16'(count_reg) >= prop_mem[IDX_FIFO_THRESH];       // RULE13
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CTS_CYCLE: assert property (cmd_valid && cts |=> !cts ##1 // RULE19
    (cts && resp_valid && resp.status[ST_CTS]))
    else $error("command answer not one cycle after take");
  AST_BUSY_NO_TAKE: assert property ( // RULE22
    !cts |-> exec_reg && !resp_valid)
    else $error("answer while still busy");
  AST_PROP_WRITE: assert property (exec_ok && // RULE21
    cmd_q_reg.code == CMD_SET_PROPERTY |=>
    prop_mem[$past(prop_idx)] == $past(cmd_q_reg.value))
    else $error("property write not stored");
  AST_REFCLK_RANGE: assert property ( // RULE8
    prop_mem[IDX_REFERENCE_CLOCK_FREQUENCY] == 16'h0000
    || (prop_mem[IDX_REFERENCE_CLOCK_FREQUENCY] >= REFCLK_MIN &&
        prop_mem[IDX_REFERENCE_CLOCK_FREQUENCY] <= REFCLK_MAX))
    else $error("reference clock out of range");
  AST_POWER_DOWN: assert property (exec_ok && // RULE1
    cmd_q_reg.code == CMD_POWER_DOWN |=> !powered ##1 resp_valid == 1'b0)
    else $error("power down not taken");
  AST_AUX_DRIVE: assert property (exec_ok && // RULE7
    cmd_q_reg.code == CMD_AUX_DRIVE |=>
    aux_output_three_oe == $past(cmd_q_reg.arg[0]))
    else $error("aux drive not applied");
  AST_RAIL: assert property (freq_err > prop_mem[IDX_MAX_TUNE_ERR] && // RULE11
    $stable(prop_mem[IDX_MAX_TUNE_ERR]) |=> freq_correction_rail_flag)
    else $error("rail flag missing");
  AST_GROUP_FLAG: assert property (group_received_flag |-> // RULE13
    16'($past(count_reg)) >= $past(prop_mem[IDX_FIFO_THRESH]))
    else $error("group flag below count");
  AST_SCAN_BAND: assert property (scan_reg == SCAN_RUN |-> // RULE14
    tuned_freq >= prop_mem[IDX_BAND_BOTTOM] &&
    tuned_freq <= prop_mem[IDX_BAND_TOP])
    else $error("scan left the band");
  AST_IRQ_MASK: assert property (int_request |-> // RULE18
    |($past(prop_mem[IDX_INT_ENABLE][7:0]) & $past(flag_vec)))
    else $error("interrupt from a disabled source");
  AST_POP_ONE: assert property (pop && !push |=> // RULE6
    count_reg == $past(count_reg) - (PW+1)'(1))
    else $error("query did not remove one entry");

  CV_SCAN_DONE: cover property (scan_reg == SCAN_RUN ##[1:1000] scan_done_reg);
  CV_PROP_READ: cover property (exec_ok &&
    cmd_q_reg.code == CMD_PROPERTY_READ_CMD);
  CV_QUEUE_POP: cover property (pop ##2 group_received_flag);
endmodule

/* File: bench/rtc_host_model.sv */
// host-side command source for the tuner engine
`timescale 1ns/100ps
module rtc_host_model (
  input  wire logic          clk,
  input  wire logic          cts,
  input  wire logic          resp_valid,
  output logic               cmd_valid,
  output rtc_pkg::rtc_cmd_type cmd
);
  import rtc_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(input logic [7:0] c, input logic [7:0] a,
                      input logic [15:0] ad, input logic [15:0] v);
    int n;
    n = 0;
    while (cts !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd = '{c, a, ad, v};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd;
    while (resp_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
endmodule

/* File: bench/radio_tuner_command_property_engine_tb_top.sv */
// self-checking bench of the tuner command engine
`timescale 1ns/100ps
module radio_tuner_command_property_engine_tb_top;
  import rtc_pkg::*;
  logic clk, rst, cmd_valid, resp_valid, cts, chan_ok, grp_v, powered;
  logic afc, rail, st_full, mo_full, sm_en, da_en, m_l, m_r, grp_f;
  logic irq, aux, aux_oe;
  logic [15:0] freq_err, grp_d, v, d0, d1, tfreq;
  logic [7:0] rssi, pmode, sm_at;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  rtc_cmd_type cmd;
  rtc_resp_type resp;
  int num_errors, checks_done, cycles;
  logic [15:0] rv[4] = '{16'h7999, 16'h8667, 16'h799a, 16'h0000};
  logic [7:0] codes[11] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h22, 8'h23,
                            8'h80, 8'h81, 8'h20, 8'h24, 8'h21};
  rtc_host_model host (.clk(clk), .cts(cts), .resp_valid(resp_valid),
    .cmd_valid(cmd_valid), .cmd(cmd));
  rtc_engine DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .resp(resp), .resp_valid(resp_valid), .cts(cts), .freq_err(freq_err),
    .rssi(rssi), .channel_valid(chan_ok), .group_valid(grp_v),
    .group_data(grp_d), .int_request(irq), .powered(powered),
    .power_mode(pmode), .tuned_freq(tfreq), .auto_freq_correction(afc),
    .freq_correction_rail_flag(rail), .stereo_full(st_full),
    .mono_full(mo_full), .soft_mute_enable(sm_en),
    .soft_mute_atten(sm_at), .digital_audio_enable(da_en),
    .mute_left(m_l), .mute_right(m_r), .group_received_flag(grp_f),
    .aux_output_three(aux), .aux_output_three_oe(aux_oe));
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] x, g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic run(input logic [7:0] c, a, input logic [15:0] ad, dv,
                     input logic er, rd, input logic [15:0] xd);
    exp_q.push_back({er, rd, xd});
    host.send(c, a, ad, dv);
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic push(input logic [15:0] d);
    grp_d = d;
    grp_v = 1'b1;
    @(posedge clk);
    #1;
    grp_v = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      num_errors++;
      print_verdict;
    end
  end
  always @(posedge clk) begin
    #2;
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare_resp", 18'h0, 18'h3ffff);
      end else begin
        e = exp_q.pop_front();
        chk("resp_cts", 18'h1, {17'h0, resp.status[ST_CTS]});
        chk("resp_err", 18'(e[17]), {17'h0, resp.status[ST_ERR]});
        if (e[16])
          chk("resp_data", 18'(e[15:0]), {2'b0, resp.data});
      end
    end
  end
  initial begin
    rst = 1'b1;
    chan_ok = 1'b0;
    grp_v = 1'b0;
    grp_d = '0;
    freq_err = '0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(25));
    rssi = 8'($urandom);
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk("cts_idle", 18'h1, {17'h0, cts});
    run(8'h12, 8'h0, 16'h1105, 16'h0, 1'b1, 1'b0, 16'h0);
    run(8'h01, 8'h05, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    settle;
    chk("power_mode", 18'h5, {10'h0, pmode});
    chk("sm_atten", 18'h10, {10'h0, sm_at});
    for (int i = 0; i < PROP_COUNT; i++)
      run(8'h13, 8'h0, PROP_ADDR[i], 16'h0, 1'b0, 1'b1,
          PROP_DEFAULT[i]);
    for (int i = 0; i < PROP_COUNT; i++) begin
      // band must enclose the later tune value for the scan
      v = (i == 3) ? 16'h799a + 16'($urandom_range(0, 16'h0ccc)) :
          (i == 17) ? 16'($urandom_range(0, 16'h22ff)) :
          (i == 18) ? 16'($urandom_range(16'h2301, 16'hffff)) :
          16'($urandom);
      run(8'h12, 8'h0, PROP_ADDR[i], v, 1'b0, 1'b0, 16'h0);
      run(8'h13, 8'h0, PROP_ADDR[i], 16'h0, 1'b0, 1'b1, v);
    end
    for (int i = 0; i < 4; i++)
      run(8'h12, 8'h0, 16'h0201, rv[i], (rv[i] != 0) &&
          (rv[i] < 16'h799a || rv[i] > 16'h8666), 1'b0, 16'h0);
    run(8'h13, 8'h0, 16'h0201, 16'h0, 1'b0, 1'b1, 16'h0);
    run(8'h12, 8'h0, 16'h0003, 16'h1, 1'b1, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h1106, 16'h007f, 1'b0, 1'b0, 16'h0);
    settle;
    chk("afc_off", 18'h0, {17'h0, afc});
    chk("mono_forced", 18'h2, {16'h0, mo_full, st_full});
    run(8'h12, 8'h0, 16'h1106, 16'h0, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h1105, 16'h0, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h1302, 16'h0, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h0104, 16'h01b8, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h4001, 16'h0002, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h1108, 16'h001e, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h1501, 16'h0002, 1'b0, 1'b0, 16'h0);
    run(8'h12, 8'h0, 16'h0001, 16'h0001, 1'b0, 1'b0, 16'h0);
    freq_err = 16'h001f;
    settle;
    chk("stereo_forced", 18'h1, {16'h0, mo_full, st_full});
    chk("soft_mute_en", 18'h0, {17'h0, sm_en});
    chk("dig_audio_en", 18'h1, {17'h0, da_en});
    chk("mute_lr", 18'h2, {16'h0, m_l, m_r});
    chk("rail_high", 18'h1, {17'h0, rail});
    freq_err = 16'h001e;
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    push(d0);
    settle;
    chk("rail_low", 18'h0, {17'h0, rail});
    chk("grp_one", 18'h0, {17'h0, grp_f});
    push(d1);
    settle;
    chk("grp_two", 18'h1, {17'h0, grp_f});
    run(8'h24, 8'h0, 16'h0, 16'h0, 1'b0, 1'b1, d0);
    settle;
    chk("grp_after_pop", 18'h0, {17'h0, grp_f});
    run(8'h24, 8'h0, 16'h0, 16'h0, 1'b0, 1'b1, d1);
    chan_ok = 1'b1;
    for (int i = 0; i < 11; i++)
      run(codes[i], 8'h09, 16'h0, 16'h2300, 1'b0, 1'b0, 16'h0);
    run(8'h30, 8'h0, 16'h0, 16'h0, 1'b1, 1'b0, 16'h0);
    run(8'h11, 8'h0, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    run(8'h13, 8'h0, 16'h1106, 16'h0, 1'b1, 1'b0, 16'h0);
    settle;
    chk("powered_off", 18'h0, {17'h0, powered});
    chk("irq_on", 18'h1, {17'h0, irq});
    chk("tuned_freq", 18'h2300, {2'h0, tfreq});
    chk("aux_pin", 18'h3, {16'h0, aux_oe, aux});
    rst = 1'b1;
    settle;
    chk("cts_in_reset", 18'h1, {17'h0, cts});
    rst = 1'b0;
    run(8'h01, 8'h01, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    run(8'h13, 8'h0, 16'h1106, 16'h0, 1'b0, 1'b1, 16'h001e);
    settle;
    chk("irq_aux_rst", 18'h0, {15'h0, irq, aux_oe, aux});
    chk("queue_empty", 18'h0, 18'(exp_q.size()));
    print_verdict;
  end
endmodule
